// *** fca_pkg.sv ***
// Summary of operation
// RULE1: read mode value: no commands taken at all
// RULE2: code mode: no blank check or configuration
// RULE3: data mode: no lock-bit commands
// RULE4: lock flag is OR of six errors
// RULE5: unacceptable command locks instead of executing
// RULE6: software checks mode and status before commands
// RULE7: running: not ready, suspendable, only suspend/stop
// RULE8: configuring: all flags zero, only forced stop
// RULE9: suspending: not ready, only forced stop legal
// RULE10: blank check/lock read: only stop, suspends kept
// RULE11: suspended states show ready and suspend flag
// RULE12: program in erase suspend: other blocks only
// RULE13: programming in erase suspend: only forced stop
// RULE14: locked and ready: clear, stop; suspend ignored
// RULE15: locked not ready: only forced stop
// RULE16: forced stop taken except as a count or data byte, clears all flags
// RULE17: idle acceptance set, suspend ignored
// RULE18: resume only in suspended states
// RULE19: blank check only in data mode
// RULE20: lock-bit commands only in code mode
// RULE21: lock read of suspended block undefined
// RULE22: ready drops at start, rises at completion
// RULE23: command first-byte opcodes
// RULE24: acceptance judged on first write only
package fca_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam logic [AW-1:0] OFF_MODE   = 8'h00;
   localparam logic [AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [AW-1:0] OFF_ACCESS = 8'h08;
   localparam logic [AW-1:0] OFF_BLOCK  = 8'h0C;
   localparam logic [AW-1:0] OFF_CMD    = 8'h10;
   localparam logic [15:0] MODE_READ_VAL = 16'h0000;
   localparam logic [15:0] MODE_CODE_VAL = 16'h0001;
   localparam logic [15:0] MODE_DATA_VAL = 16'h0080;
   localparam logic [15:0] MODE_RST      = 16'h0000;
   localparam logic [15:0] BLOCK_RST     = 16'h0000;
   // status word bit positions
   localparam int ST_RDY_BIT = 0;
   localparam int ST_SRDY_BIT = 1;
   localparam int ST_ESPD_BIT = 2;
   localparam int ST_PSPD_BIT = 3;
   localparam int ST_ERR_LSB = 4;
   localparam int ACC_LOCK_BIT = 0;
   // first bytes, and the final byte
   localparam logic [7:0] OP_PROG  = 8'hE8; // RULE23
   localparam logic [7:0] OP_ERASE = 8'h20;
   localparam logic [7:0] OP_SUSP  = 8'hB0;
   localparam logic [7:0] OP_RES   = 8'hD0;
   localparam logic [7:0] OP_CLR   = 8'h50;
   localparam logic [7:0] OP_FSTOP = 8'hB3;
   localparam logic [7:0] OP_BCLR  = 8'h71;
   localparam logic [7:0] OP_CFG   = 8'h40;
   localparam logic [7:0] OP_LBP   = 8'h77;
   localparam logic [7:0] OP_FINAL = 8'hD0;

   typedef enum logic [1:0] {MD_READ, MD_CODE, MD_DATA} fca_mode_e;
   typedef enum logic [3:0] {
      S_IDLE, S_COLLECT, S_RUN, S_CFG, S_SUSPENDING, S_BCLR,
      S_PSUSP, S_ESUSP, S_PRG_IN_ERS, S_LBP, S_FSTOP
   } fca_state_e;
   typedef enum logic [1:0] {PH_COUNT, PH_DATA, PH_FINAL} fca_phase_e;
   typedef enum logic [1:0] {V_ACC, V_IGN, V_ILL} fca_verdict_e;

   // error flags reported by the execution engine, one-cycle pulses
   typedef struct packed {
      logic lock_write_err;
      logic read_detect_err;
      logic fw_unit_err;
      logic program_err;
      logic erase_err;
   } fca_exec_err_s;

   typedef struct packed {
      logic        start;
      logic [7:0]  cmd;
      logic [15:0] block;
   } fca_exec_req_s;
endpackage

// *** fca_top.sv ***
`timescale 1ns/1ps
module fca_top
   import fca_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   output logic      [DW-1:0] rd_data,
   input  wire logic          exec_done,
   input  wire logic          exec_suspended,
   input  fca_exec_err_s      exec_err,
   output fca_exec_req_s      exec_req,
   output logic      [15:0]   exec_data,
   output logic               exec_data_valid
);
   logic [15:0]   mode_entry_reg;
   logic [15:0]   block_reg;
   logic [DW-1:0] rd_data_reg;
   fca_state_e    state_reg;
   fca_state_e    ret_reg;
   fca_phase_e    phase_reg;
   logic [7:0]    col_cmd_reg;
   logic [7:0]    col_cnt_reg;
   logic [15:0]   col_blk_reg;
   logic [15:0]   ers_blk_reg;
   logic          run_prog_reg;
   logic          ready_flag;
   logic          erase_suspended_flag;
   logic          program_suspended_flag;
   logic          illegal_cmd_err;
   fca_exec_err_s err_reg;
   fca_exec_req_s req_reg;
   logic [15:0]   xdata_reg;
   logic          xvalid_reg;

   fca_mode_e    mode;
   logic         cmd_wr;
   logic         first_wr;
   logic [7:0]   op;
   fca_verdict_e verdict;
   logic         acc_first;
   logic         fin_ok;
   logic         col_fstop;
   logic         col_bad;
   logic         fs_evt;
   logic         clr_evt;
   logic         ill_evt;
   logic         suspend_ready_flag;
   logic         cmd_lock_flag;
   logic [DW-1:0] status_word;

   function automatic fca_mode_e mode_f(input logic [15:0] v);
      if (v == MODE_CODE_VAL)
         return MD_CODE;
      else if (v == MODE_DATA_VAL)
         return MD_DATA;
      else
         return MD_READ;
   endfunction

   // acceptance matrix: mode first, then forced stop, lock, state
   function automatic fca_verdict_e verdict_f(
      input logic [7:0] c,
      input fca_mode_e  md,
      input fca_state_e st,
      input logic       lk,
      input logic       rdy,
      input logic       same_blk
   );
      fca_verdict_e v;
      v = V_ILL;
      if (md == MD_READ)
         v = V_IGN;                                   // RULE1
      else if (c == OP_FSTOP)
         v = V_ACC;                                   // RULE16
      else if (lk)
      begin
         if (rdy && c == OP_CLR)
            v = V_ACC;                                // RULE14
         else if (rdy && c == OP_SUSP)
            v = V_IGN;                                // RULE14
         else
            v = V_ILL;                                // RULE15
      end
      else
      begin
         unique case (st)
            S_IDLE:
            begin
               // 71h is blank check in data mode, lock read in code mode
               if (c == OP_PROG || c == OP_ERASE || c == OP_CLR ||
                   c == OP_BCLR)
                  v = V_ACC;                          // RULE17 RULE19
               else if (c == OP_SUSP)
                  v = V_IGN;                          // RULE17
               else if (c == OP_CFG && md == MD_DATA)
                  v = V_ACC;                          // RULE2 RULE3
               else if (c == OP_LBP && md == MD_CODE)
                  v = V_ACC;                          // RULE20 RULE3
            end
            S_RUN:
               if (c == OP_SUSP)
                  v = V_ACC;                          // RULE7
            S_PSUSP, S_ESUSP:
            begin
               if (c == OP_RES || c == OP_CLR || c == OP_BCLR)
                  v = V_ACC;                          // RULE11 RULE18
               else if (c == OP_PROG && st == S_ESUSP && !same_blk)
                  v = V_ACC;                          // RULE12
            end
            S_COLLECT, S_CFG, S_SUSPENDING, S_BCLR, S_PRG_IN_ERS,
            S_LBP, S_FSTOP:
               v = V_ILL;                             // RULE8 RULE9 RULE13
         endcase
      end
      return v;
   endfunction

   assign mode = mode_f(mode_entry_reg);
   assign cmd_lock_flag = illegal_cmd_err | (|err_reg);        // RULE4
   assign suspend_ready_flag = (state_reg == S_RUN);           // RULE7
   assign status_word = {{(DW - ST_ERR_LSB - 6){1'b0}},
                         err_reg.lock_write_err, err_reg.read_detect_err,
                         err_reg.fw_unit_err, err_reg.program_err,
                         err_reg.erase_err, illegal_cmd_err,
                         program_suspended_flag, erase_suspended_flag,
                         suspend_ready_flag, ready_flag};

   always_comb
   begin
      cmd_wr    = wr_en && (addr == OFF_CMD) && (mode != MD_READ);
      op        = wr_data[7:0];
      first_wr  = cmd_wr && (state_reg != S_COLLECT);       // RULE24
      verdict   = verdict_f(op, mode, state_reg, cmd_lock_flag, ready_flag,
                            block_reg == ers_blk_reg);
      acc_first = first_wr && (verdict == V_ACC);
      fin_ok    = cmd_wr && (state_reg == S_COLLECT) &&
                  (phase_reg == PH_FINAL) && (op == OP_FINAL);
      col_fstop = cmd_wr && (state_reg == S_COLLECT) &&
                  (phase_reg == PH_FINAL) && (op == OP_FSTOP);
      col_bad   = cmd_wr && (state_reg == S_COLLECT) &&
                  (phase_reg == PH_FINAL) && !fin_ok && !col_fstop;
      fs_evt    = (acc_first && op == OP_FSTOP) || col_fstop;
      clr_evt   = acc_first && (op == OP_CLR);
      ill_evt   = (first_wr && verdict == V_ILL) || col_bad;   // RULE5
   end

   // software registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_entry_reg <= MODE_RST;
         block_reg      <= BLOCK_RST;
      end
      else if (wr_en)
      begin
         if (addr == OFF_MODE)
            mode_entry_reg <= wr_data[15:0];
         if (addr == OFF_BLOCK)
            block_reg <= wr_data[15:0];
      end
   end

   // read data stands for one cycle only; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data_reg <= '0;
      else if (!rd_en)
         rd_data_reg <= '0;
      else
      begin
         unique case (addr)
            OFF_MODE:   rd_data_reg <= {16'h0000, mode_entry_reg};
            OFF_STATUS: rd_data_reg <= status_word;
            OFF_ACCESS: rd_data_reg <= {{(DW-1){1'b0}}, cmd_lock_flag};
            OFF_BLOCK:  rd_data_reg <= {16'h0000, block_reg};
            default:    rd_data_reg <= '0;
         endcase
      end
   end

   // error flags: hardware set wins over any clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         illegal_cmd_err <= 1'b0;
         err_reg         <= '0;
      end
      else
      begin
         if (ill_evt)
            illegal_cmd_err <= 1'b1;                  // RULE5
         else if (clr_evt || fs_evt)
            illegal_cmd_err <= 1'b0;
         // status clear leaves fw/read-detect/lock-write errors standing
         err_reg.erase_err <= exec_err.erase_err ||
            (err_reg.erase_err && !clr_evt && !fs_evt);
         err_reg.program_err <= exec_err.program_err ||
            (err_reg.program_err && !clr_evt && !fs_evt);
         err_reg.fw_unit_err <= exec_err.fw_unit_err ||
            (err_reg.fw_unit_err && !fs_evt);
         err_reg.read_detect_err <= exec_err.read_detect_err ||
            (err_reg.read_detect_err && !fs_evt);
         err_reg.lock_write_err <= exec_err.lock_write_err ||
            (err_reg.lock_write_err && !fs_evt);
      end
   end

   // sequencer state, ready and suspended flags
   // a command written in the very cycle the engine finishes is judged
   // against the old state; only forced stop overrides completion
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg              <= S_IDLE;
         ret_reg                <= S_IDLE;
         phase_reg              <= PH_COUNT;
         col_cmd_reg            <= 8'h00;
         col_cnt_reg            <= 8'h00;
         col_blk_reg            <= BLOCK_RST;
         ers_blk_reg            <= BLOCK_RST;
         run_prog_reg           <= 1'b0;
         ready_flag             <= 1'b1;
         erase_suspended_flag   <= 1'b0;
         program_suspended_flag <= 1'b0;
      end
      else if (fs_evt)
      begin
         state_reg              <= S_FSTOP;           // RULE16
         ready_flag             <= 1'b0;              // RULE16
         erase_suspended_flag   <= 1'b0;
         program_suspended_flag <= 1'b0;
      end
      else if (exec_done && state_reg != S_IDLE && state_reg != S_COLLECT &&
               state_reg != S_PSUSP && state_reg != S_ESUSP)
      begin
         ready_flag <= 1'b1;                          // RULE22
         unique case (state_reg)
            S_SUSPENDING:
            begin
               // finishing before the suspend took effect is not an error
               if (exec_suspended && run_prog_reg)
               begin
                  state_reg              <= S_PSUSP;  // RULE11
                  program_suspended_flag <= 1'b1;
               end
               else if (exec_suspended)
               begin
                  state_reg            <= S_ESUSP;    // RULE11
                  erase_suspended_flag <= 1'b1;
               end
               else
                  state_reg <= S_IDLE;
            end
            S_PRG_IN_ERS:
               state_reg <= S_ESUSP;
            S_BCLR:
               state_reg <= erase_suspended_flag   ? S_ESUSP :
                            program_suspended_flag ? S_PSUSP : S_IDLE;
            default:
               state_reg <= S_IDLE;
         endcase
      end
      else if (ill_evt && state_reg == S_COLLECT)
         state_reg <= ret_reg;
      else if (acc_first)
      begin
         unique case (op)
            OP_SUSP:
               state_reg <= S_SUSPENDING;             // RULE9
            OP_RES:
            begin
               state_reg              <= S_RUN;       // RULE18
               ready_flag             <= 1'b0;        // RULE22
               erase_suspended_flag   <= 1'b0;
               program_suspended_flag <= 1'b0;
            end
            OP_PROG, OP_ERASE, OP_BCLR, OP_CFG, OP_LBP:
            begin
               state_reg   <= S_COLLECT;
               ret_reg     <= state_reg;
               col_cmd_reg <= op;
               col_blk_reg <= block_reg;
               phase_reg   <= (op == OP_PROG || op == OP_CFG) ?
                              PH_COUNT : PH_FINAL;
            end
            default:
               state_reg <= state_reg;                // status clear
         endcase
      end
      else if (cmd_wr && state_reg == S_COLLECT)
      begin
         unique case (phase_reg)
            PH_COUNT:
            begin
               col_cnt_reg <= op;
               phase_reg   <= (op == 8'h00) ? PH_FINAL : PH_DATA;
            end
            PH_DATA:
            begin
               col_cnt_reg <= col_cnt_reg - 8'h01;
               if (col_cnt_reg == 8'h01)
                  phase_reg <= PH_FINAL;
            end
            PH_FINAL:
            begin
               ready_flag <= 1'b0;                    // RULE22
               unique case (col_cmd_reg)
                  OP_PROG:
                  begin
                     state_reg    <= (ret_reg == S_ESUSP) ?
                                     S_PRG_IN_ERS : S_RUN;  // RULE13
                     run_prog_reg <= 1'b1;
                  end
                  OP_ERASE:
                  begin
                     state_reg    <= S_RUN;           // RULE7
                     run_prog_reg <= 1'b0;
                     ers_blk_reg  <= col_blk_reg;
                  end
                  OP_BCLR:
                     state_reg <= S_BCLR;             // RULE10
                  OP_CFG:
                     state_reg <= S_CFG;              // RULE8
                  default:
                     state_reg <= S_LBP;
               endcase
            end
         endcase
      end
   end

   // requests to the execution engine; a lock read aimed at the
   // suspended erase block is passed on, its result is undefined RULE21
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_reg    <= '0;
         xdata_reg  <= 16'h0000;
         xvalid_reg <= 1'b0;
      end
      else
      begin
         req_reg.start <= 1'b0;
         xvalid_reg    <= 1'b0;
         if (fs_evt || (acc_first && (op == OP_SUSP || op == OP_RES)))
         begin
            req_reg.start <= 1'b1;
            req_reg.cmd   <= fs_evt ? OP_FSTOP : op;
            req_reg.block <= (op == OP_RES) ? ers_blk_reg : block_reg;
         end
         else if (fin_ok)
         begin
            req_reg.start <= 1'b1;
            req_reg.cmd   <= col_cmd_reg;
            req_reg.block <= col_blk_reg;
         end
         if (cmd_wr && state_reg == S_COLLECT && phase_reg == PH_DATA)
         begin
            xdata_reg  <= wr_data[15:0];
            xvalid_reg <= 1'b1;
         end
      end
   end

   assign rd_data         = rd_data_reg;
   assign exec_req        = req_reg;
   assign exec_data       = xdata_reg;
   assign exec_data_valid = xvalid_reg;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   chk_lock_read: assert property (                    // RULE4
      rd_en && addr == OFF_ACCESS |=> rd_data[ACC_LOCK_BIT] ==
      $past(illegal_cmd_err || (|err_reg)))
      else $error("access status lock bit disagrees with errors");
   chk_read_mode: assert property (                    // RULE1
      wr_en && addr == OFF_CMD && mode == MD_READ && !exec_done |=>
      $stable(state_reg) && !exec_req.start)
      else $error("command acted upon in read mode");
   chk_illegal_lock: assert property (                 // RULE5
      first_wr && verdict == V_ILL |=> cmd_lock_flag && !exec_req.start)
      else $error("illegal command did not lock");
   chk_run_flags: assert property (                    // RULE7
      state_reg == S_RUN |-> !ready_flag && status_word[ST_SRDY_BIT] &&
      !erase_suspended_flag && !program_suspended_flag)
      else $error("running flags wrong");
   chk_cfg_flags: assert property (                    // RULE8
      state_reg == S_CFG |-> status_word[3:0] == 4'h0)
      else $error("configuration flags wrong");
   chk_suspending_flags: assert property (             // RULE9
      state_reg == S_SUSPENDING |-> !ready_flag && !suspend_ready_flag)
      else $error("suspending flags wrong");
   chk_fstop_any: assert property (                    // RULE16
      first_wr && op == OP_FSTOP |=> state_reg == S_FSTOP &&
      exec_req.start && exec_req.cmd == OP_FSTOP && !ready_flag)
      else $error("forced stop not taken");
   chk_resume_only: assert property (                  // RULE18
      first_wr && op == OP_RES && state_reg != S_PSUSP &&
      state_reg != S_ESUSP |=> illegal_cmd_err)
      else $error("resume outside suspend not locked");
   chk_same_block: assert property (                   // RULE12
      first_wr && op == OP_PROG && state_reg == S_ESUSP &&
      block_reg == ers_blk_reg |=> illegal_cmd_err)
      else $error("program to suspended erase block taken");
   chk_ready_drop: assert property (                   // RULE22
      fin_ok && !exec_done |=> !ready_flag ##0 exec_req.start)
      else $error("ready not dropped at command start");
   chk_clr_keeps: assert property (                    // RULE14
      clr_evt && !ill_evt |=> $stable(ready_flag) && !illegal_cmd_err)
      else $error("status clear misbehaved");

   cov_erase_suspend: cover property (
      state_reg == S_SUSPENDING ##1 state_reg == S_ESUSP);
   cov_prog_in_ers: cover property (state_reg == S_PRG_IN_ERS);
   cov_locked_clear: cover property (cmd_lock_flag ##[1:20] clr_evt);
   cov_blank_check: cover property (state_reg == S_BCLR && mode == MD_DATA);
endmodule

// *** tb_flash_command_acceptance.sv ***
`timescale 1ns/1ps
module tb_flash_command_acceptance
   import fca_pkg::*;
;
   logic          sys_clk;
   logic          rst_n;
   logic [AW-1:0] addr;
   logic [DW-1:0] wr_data;
   logic          wr_en;
   logic          rd_en;
   logic [DW-1:0] rd_data;
   logic          exec_done;
   logic          exec_suspended;
   fca_exec_err_s exec_err;
   fca_exec_req_s exec_req;
   logic [15:0]   exec_data;
   logic          exec_data_valid;
   int            error_cnt;
   int            n_compared;
   int            op_q[$];
   int            blk_q[$];
   int            dq[$];
   logic [31:0]   v;
   logic [15:0]   b1;
   logic [15:0]   b2;

   fca_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .exec_done(exec_done), .exec_suspended(exec_suspended),
      .exec_err(exec_err), .exec_req(exec_req), .exec_data(exec_data),
      .exec_data_valid(exec_data_valid));

   task automatic summarize();
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   // one idle cycle after each strobe so no strobe is driven twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
      @(posedge sys_clk);
   endtask

   task automatic cmd(input logic [7:0] op);
      wr(OFF_CMD, {24'h0, op});
   endtask

   task automatic chk(input logic r, s, e, p, input logic [5:0] er);
      logic [31:0] d;
      rd(OFF_STATUS, d);
      cmp("status", {22'h0, er, p, e, s, r}, d);
      rd(OFF_ACCESS, d);
      cmp("cmd_lock_flag", {31'h0, |er}, d);
   endtask

   // accepted command: every byte of its sequence, start expected
   task automatic issue(input logic [7:0] op, input int n, input int blk);
      logic [15:0] w;
      // queued first: the monitor sees start on the edge the last write ends
      op_q.push_back(op);
      blk_q.push_back(blk);
      cmd(op);
      if (op == OP_PROG || op == OP_CFG)
      begin
         cmd(n[7:0]);
         repeat (n)
         begin
            w = 16'($urandom);
            dq.push_back(w);
            wr(OFF_CMD, {16'h0, w});
         end
      end
      if (op inside {OP_PROG, OP_CFG, OP_ERASE, OP_BCLR, OP_LBP})
         cmd(OP_FINAL);
   endtask

   task automatic done(input logic s);
      exec_done <= 1'b1;
      exec_suspended <= s;
      @(posedge sys_clk);
      exec_done <= 1'b0;
      exec_suspended <= 1'b0;
      @(posedge sys_clk);
   endtask

   always @(posedge sys_clk)
   begin
      int b;
      if (exec_req.start === 1'b1)
      begin
         if (op_q.size() == 0)
            cmp("exec_start", 32'h0, 32'h1);
         else
         begin
            cmp("exec_cmd", op_q.pop_front(), {24'h0, exec_req.cmd});
            b = blk_q.pop_front();
            if (b >= 0)
               cmp("exec_block", b, {16'h0, exec_req.block});
         end
      end
      if (exec_data_valid === 1'b1)
         cmp("exec_data", dq.size() ? dq.pop_front() : -1, {16'h0, exec_data});
   end

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (6000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end

   initial
   begin
      rst_n = 1'b0;
      {addr, wr_data, wr_en, rd_en, exec_done, exec_suspended} = '0;
      exec_err = '0;
      error_cnt = 0;
      n_compared = 0;
      void'($urandom(29));
      b1 = 16'($urandom_range(0, 16'hFFFE));
      b2 = b1 + 16'h0001;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(OFF_MODE, v);
      cmp("mode_entry_reg", 32'h0, v);
      chk(1, 0, 0, 0, 6'h00);
      rd(8'h1C, v);
      cmp("unmapped", 32'h0, v);
      cmd(OP_ERASE);
      cmd(OP_FINAL);
      chk(1, 0, 0, 0, 6'h00);
      wr(OFF_MODE, {16'h0, MODE_CODE_VAL});
      rd(OFF_MODE, v);
      cmp("mode_entry_reg", 32'h1, v);
      cmd(OP_SUSP);
      chk(1, 0, 0, 0, 6'h00);
      cmd(OP_CFG);
      chk(1, 0, 0, 0, 6'h01);
      cmd(OP_RES);
      chk(1, 0, 0, 0, 6'h01);
      cmd(OP_CLR);
      chk(1, 0, 0, 0, 6'h00);
      issue(OP_BCLR, 0, -1);
      chk(0, 0, 0, 0, 6'h00);
      done(1'b0);
      chk(1, 0, 0, 0, 6'h00);
      wr(OFF_BLOCK, {16'h0, b1});
      issue(OP_ERASE, 0, b1);
      chk(0, 1, 0, 0, 6'h00);
      exec_err <= 5'b00010;
      @(posedge sys_clk);
      exec_err <= '0;
      done(1'b0);
      chk(1, 0, 0, 0, 6'h04);
      cmd(OP_SUSP);
      chk(1, 0, 0, 0, 6'h04);
      cmd(OP_CLR);
      issue(OP_ERASE, 0, b1);
      issue(OP_SUSP, 0, -1);
      chk(0, 0, 0, 0, 6'h00);
      done(1'b1);
      chk(1, 0, 1, 0, 6'h00);
      wr(OFF_BLOCK, {16'h0, b2});
      rd(OFF_BLOCK, v);
      cmp("block_reg", {16'h0, b2}, v);
      issue(OP_PROG, 1, b2);
      chk(0, 0, 1, 0, 6'h00);
      done(1'b0);
      chk(1, 0, 1, 0, 6'h00);
      wr(OFF_BLOCK, {16'h0, b1});
      cmd(OP_PROG);
      chk(1, 0, 1, 0, 6'h01);
      issue(OP_FSTOP, 0, -1);
      chk(0, 0, 0, 0, 6'h00);
      done(1'b0);
      chk(1, 0, 0, 0, 6'h00);
      issue(OP_PROG, 2, b1);
      issue(OP_SUSP, 0, -1);
      done(1'b1);
      chk(1, 0, 0, 1, 6'h00);
      issue(OP_RES, 0, -1);
      chk(0, 1, 0, 0, 6'h00);
      done(1'b0);
      cmd(OP_RES);
      chk(1, 0, 0, 0, 6'h01);
      cmd(OP_CLR);
      issue(OP_LBP, 0, b1);
      done(1'b0);
      cmd(OP_ERASE);
      cmd(OP_CLR);
      chk(1, 0, 0, 0, 6'h01);
      cmd(OP_CLR);
      cmd(OP_ERASE);
      issue(OP_FSTOP, 0, -1);
      done(1'b0);
      chk(1, 0, 0, 0, 6'h00);
      wr(OFF_MODE, {16'h0, MODE_DATA_VAL});
      cmd(OP_LBP);
      chk(1, 0, 0, 0, 6'h01);
      cmd(OP_CLR);
      issue(OP_BCLR, 0, -1);
      done(1'b0);
      issue(OP_CFG, 2, -1);
      chk(0, 0, 0, 0, 6'h00);
      done(1'b0);
      chk(1, 0, 0, 0, 6'h00);
      repeat (3) @(posedge sys_clk);
      cmp("pending_starts", 32'h0, op_q.size());
      cmp("pending_data", 32'h0, dq.size());
      summarize();
   end
endmodule
